// >>> hw/oovr_pkg.sv
// Constants, types and register map of the output manual override block
package oovr_pkg;
	localparam int CLK_MHZ = 250;
	localparam int CLK_NS = 1000 / CLK_MHZ;
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int DEBOUNCE_MS = 10;
	localparam int BUS_FAIL_MS = 1000;
	localparam int HOLD_MS = 3000;
	localparam int BLINK_HALF_MS = 500;
	localparam int SEC_MS = 1000;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_OUT_CMD = 8'h08;
	localparam logic [7:0] ADDR_TIMED_CMD = 8'h0c;
	localparam logic [7:0] ADDR_EVENT = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam int CTRL_W = 7;
	localparam int EVENT_UPLOAD_BIT = 0;
	localparam int TIMING_START_LSB = 0;
	localparam int TIMING_TMO_LSB = 16;
	localparam int STATUS_MODE_LSB = 0;
	localparam int STATUS_TX_BIT = 2;
	localparam int STATUS_AUXF_LSB = 3;
	localparam int STATUS_SW_LSB = 8;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [15:0] START_MS_RST = 16'h0064;
	localparam logic [15:0] TMO_S_RST = 16'h0000;
	typedef enum logic [1:0] {
		OOVR_NORMAL = 2'b00,
		OOVR_MANUAL = 2'b01,
		OOVR_FAIL = 2'b11,
		OOVR_PROG = 2'b10
	} oovr_mode_type;
	typedef struct packed {
		logic [1:0] alarm_en;
		logic timeout_en;
		logic inhibit;
		logic bus_ctrl;
		logic man_dis;
		logic configured;
	} oovr_ctrl_type;
	typedef struct packed {
		logic [15:0] tmo_s;
		logic [15:0] start_ms;
	} oovr_timing_type;
endpackage : oovr_pkg

// >>> hw/oovr_top.sv
// Mode, manual override and supply supervision for an eight-output valve actuator
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
// Function
// R1 - Programming key enters mode, LED steady on
// R2 - Upload completion returns normal, LED off
// R3 - Transmit only after configurable start-up delay
// R4 - Bus low over 1 s: outputs off
// R5 - Bus restore resumes previous state
// R6 - Missing aux supply blinks LED groups 1 s
// R7 - Supply fault always detected, two optional alarms
// R8 - Entering manual leaves outputs unchanged
// R9 - Manual mode ignores bus output commands
// R10 - Manual output changes send no status frame
// R11 - LEDs show actual outputs in manual mode
// R12 - Manual state kept until next bus command
// R13 - Timed functions ignored in manual mode
// R14 - Hold key over 3 s enters manual
// R15 - Output key press toggles its output
// R16 - Manual key press returns to normal
// R17 - Manual entry blockable by configuration or bus
// R18 - Bus inhibit blocks key only, never switches
// R19 - Optional timeout leaves manual mode automatically
// R20 - Unconfigured: no bus tasks, manual allowed
// R21 - Keys debounced, one event per press
module oovr_top import oovr_pkg::*; #(
	parameter int MS_CYCLES = MS_CYC
) (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic [31:0] hrdata_out,
	input wire logic prog_key_in,
	input wire logic manual_key_in,
	input wire logic [7:0] output_key_in,
	input wire logic bus_volt_low_in,
	input wire logic [1:0] aux_ok_in,
	output logic [7:0] out_switch_out,
	output logic [7:0] led_out,
	output logic prog_led_out,
	output logic manual_led_out,
	output logic tx_enable_out,
	output logic status_frame_out,
	output logic [1:0] alarm_out
);
	oovr_mode_type mode_r;
	oovr_mode_type saved_r;
	oovr_ctrl_type ctrl_r;
	oovr_timing_type timing_r;
	logic [7:0] addr_r;
	logic wr_r;
	logic sel_r;
	logic [31:0] ms_cnt_r;
	logic ms_tick;
	logic [3:0] deb_cnt_r;
	logic [9:0] samp_r;
	logic [9:0] stable_r;
	logic [9:0] stable_d_r;
	logic [9:0] press;
	logic prog_press;
	logic man_press;
	logic [7:0] out_press;
	logic [15:0] low_cnt_r;
	logic fail_det;
	logic [15:0] hold_cnt_r;
	logic long_ev;
	logic [15:0] sec_ms_r;
	logic [15:0] man_sec_r;
	logic [15:0] start_cnt_r;
	logic [15:0] blink_cnt_r;
	logic blink_r;
	logic [7:0] out_state_r;
	logic blocked;
	logic tmo_allowed;
	logic tmo_hit;
	logic upload_ev;
	logic bus_wr_ev;
	logic timed_wr_ev;
	logic auto_ok;

	function automatic logic wr_hit(input logic s, input logic w, input logic [7:0] a, input logic [7:0] ref_a);
		wr_hit = s & w & (a == ref_a);
	endfunction : wr_hit

	// AHB-Lite slave: zero wait states, OKAY only
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			sel_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			sel_r <= hsel_in & htrans_in[1] & hready_in;
			wr_r <= hwrite_in;
			addr_r <= haddr_in[7:0];
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// Read data prepared in the address phase so it stands for the data phase
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (hsel_in & htrans_in[1] & hready_in & !hwrite_in) begin
			if (haddr_in[7:0] == ADDR_CTRL) begin
				hrdata_out <= {25'h0000000, ctrl_r};
			end else if (haddr_in[7:0] == ADDR_TIMING) begin
				hrdata_out <= timing_r;
			end else if (haddr_in[7:0] == ADDR_OUT_CMD) begin
				hrdata_out <= {24'h000000, out_state_r};
			end else if (haddr_in[7:0] == ADDR_STATUS) begin
				hrdata_out <= {16'h0000, out_switch_out, 3'h0, ~aux_ok_in, tx_enable_out, mode_r}; // R7
			end else begin
				hrdata_out <= 32'h0000_0000;
			end
		end
	end

	assign upload_ev = wr_hit(sel_r, wr_r, addr_r, ADDR_EVENT) & hwdata_in[EVENT_UPLOAD_BIT];
	assign bus_wr_ev = wr_hit(sel_r, wr_r, addr_r, ADDR_OUT_CMD);
	assign timed_wr_ev = wr_hit(sel_r, wr_r, addr_r, ADDR_TIMED_CMD);

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			ctrl_r <= oovr_ctrl_type'(CTRL_RST);
			timing_r <= {TMO_S_RST, START_MS_RST};
		end else if (wr_hit(sel_r, wr_r, addr_r, ADDR_CTRL)) begin
			ctrl_r <= oovr_ctrl_type'(hwdata_in[CTRL_W-1:0]);
		end else if (wr_hit(sel_r, wr_r, addr_r, ADDR_TIMING)) begin
			timing_r <= hwdata_in;
		end
	end

	// Shared millisecond tick keeps every long count small
	assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
	always_ff @(posedge clock_in) begin
		if (!nrst_in || ms_tick) begin
			ms_cnt_r <= 32'h0000_0000;
		end else begin
			ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
		end
	end

	// Two agreeing samples a debounce period apart make a level stable
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			deb_cnt_r <= 4'h0;
			samp_r <= 10'h000;
			stable_r <= 10'h000;
		end else if (ms_tick) begin
			if (deb_cnt_r == 4'(DEBOUNCE_MS - 1)) begin
				deb_cnt_r <= 4'h0;
				samp_r <= {prog_key_in, manual_key_in, output_key_in};
				stable_r <= ({prog_key_in, manual_key_in, output_key_in} & samp_r) |
					(stable_r & ({prog_key_in, manual_key_in, output_key_in} | samp_r)); // R21
			end else begin
				deb_cnt_r <= deb_cnt_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			stable_d_r <= 10'h000;
		end else begin
			stable_d_r <= stable_r;
		end
	end
	assign press = stable_r & ~stable_d_r; // R21
	assign prog_press = press[9];
	assign man_press = press[8];
	assign out_press = press[7:0];

	// Bus undervoltage must persist beyond the limit
	always_ff @(posedge clock_in) begin
		if (!nrst_in || !bus_volt_low_in) begin
			low_cnt_r <= 16'h0000;
		end else if (ms_tick && low_cnt_r <= 16'(BUS_FAIL_MS)) begin
			low_cnt_r <= low_cnt_r + 16'h0001;
		end
	end
	assign fail_det = bus_volt_low_in & (low_cnt_r > 16'(BUS_FAIL_MS)); // R4

	// Long press measured in milliseconds, saturating so it fires once
	always_ff @(posedge clock_in) begin
		if (!nrst_in || !stable_r[8]) begin
			hold_cnt_r <= 16'h0000;
		end else if (ms_tick && hold_cnt_r <= 16'(HOLD_MS)) begin
			hold_cnt_r <= hold_cnt_r + 16'h0001;
		end
	end
	assign long_ev = ms_tick & stable_r[8] & (hold_cnt_r == 16'(HOLD_MS)); // R14 R21

	assign blocked = ctrl_r.man_dis | (ctrl_r.bus_ctrl & ctrl_r.inhibit); // R17 R18
	assign tmo_allowed = ctrl_r.timeout_en & !ctrl_r.man_dis & !ctrl_r.bus_ctrl; // R19
	assign tmo_hit = tmo_allowed & (man_sec_r >= timing_r.tmo_s);

	always_ff @(posedge clock_in) begin
		if (!nrst_in || mode_r != OOVR_MANUAL) begin
			sec_ms_r <= 16'h0000;
			man_sec_r <= 16'h0000;
		end else if (ms_tick) begin
			if (sec_ms_r == 16'(SEC_MS - 1)) begin
				sec_ms_r <= 16'h0000;
				man_sec_r <= man_sec_r + 16'h0001;
			end else begin
				sec_ms_r <= sec_ms_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			mode_r <= OOVR_NORMAL;
			saved_r <= OOVR_NORMAL;
		end else begin
			case (mode_r)
				OOVR_NORMAL: begin
					if (fail_det) begin
						saved_r <= mode_r; // R5
						mode_r <= OOVR_FAIL; // R4
					end else if (prog_press) begin
						mode_r <= OOVR_PROG; // R1
					end else if (long_ev && !blocked) begin
						mode_r <= OOVR_MANUAL; // R14 R17 R20
					end
				end
				OOVR_MANUAL: begin
					if (fail_det) begin
						saved_r <= mode_r; // R5
						mode_r <= OOVR_FAIL;
					end else if ((man_press && !blocked) || tmo_hit) begin
						mode_r <= OOVR_NORMAL; // R16 R19
					end
				end
				OOVR_PROG: begin
					if (fail_det) begin
						saved_r <= mode_r;
						mode_r <= OOVR_FAIL;
					end else if (upload_ev) begin
						mode_r <= OOVR_NORMAL; // R2
					end
				end
				default: begin
					if (!bus_volt_low_in) begin
						mode_r <= saved_r; // R5
					end
				end
			endcase
		end
	end

	// Bus and timed writes only in normal or programming mode and when configured
	assign auto_ok = (mode_r == OOVR_NORMAL || mode_r == OOVR_PROG) & ctrl_r.configured; // R9 R13 R20
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			out_state_r <= 8'h00;
			status_frame_out <= 1'b0;
		end else begin
			status_frame_out <= 1'b0;
			if (mode_r == OOVR_MANUAL) begin
				out_state_r <= out_state_r ^ out_press; // R8 R15
			end else if (auto_ok && bus_wr_ev) begin
				out_state_r <= hwdata_in[7:0]; // R12
				status_frame_out <= tx_enable_out & (hwdata_in[7:0] != out_state_r); // R3 R10
			end else if (auto_ok && timed_wr_ev) begin
				out_state_r <= hwdata_in[7:0];
				status_frame_out <= tx_enable_out & (hwdata_in[7:0] != out_state_r);
			end
		end
	end

	// Start-up delay restarts whenever bus failure mode ends
	always_ff @(posedge clock_in) begin
		if (!nrst_in || mode_r == OOVR_FAIL) begin
			start_cnt_r <= 16'h0000;
			tx_enable_out <= 1'b0;
		end else begin
			if (ms_tick && start_cnt_r < timing_r.start_ms) begin
				start_cnt_r <= start_cnt_r + 16'h0001;
			end
			tx_enable_out <= ctrl_r.configured & (start_cnt_r >= timing_r.start_ms); // R3 R20
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			blink_cnt_r <= 16'h0000;
			blink_r <= 1'b0;
		end else if (ms_tick) begin
			if (blink_cnt_r == 16'(BLINK_HALF_MS - 1)) begin
				blink_cnt_r <= 16'h0000;
				blink_r <= ~blink_r; // R6
			end else begin
				blink_cnt_r <= blink_cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			out_switch_out <= 8'h00;
			led_out <= 8'h00;
			prog_led_out <= 1'b0;
			manual_led_out <= 1'b0;
			alarm_out <= 2'b00;
		end else begin
			out_switch_out <= (mode_r == OOVR_FAIL) ? 8'h00 : out_state_r; // R4
			for (int g = 0; g < 2; g++) begin
				if (mode_r == OOVR_FAIL) begin
					led_out[g*4 +: 4] <= 4'h0;
				end else if (!aux_ok_in[g]) begin
					led_out[g*4 +: 4] <= {4{blink_r}}; // R6
				end else begin
					led_out[g*4 +: 4] <= out_state_r[g*4 +: 4]; // R11 R16
				end
			end
			prog_led_out <= (mode_r == OOVR_PROG); // R1 R2
			manual_led_out <= (mode_r == OOVR_MANUAL); // R14
			alarm_out <= ctrl_r.alarm_en & ~aux_ok_in & {2{tx_enable_out}}; // R7
		end
	end

	sequence s_upload_in_prog;
		mode_r == OOVR_PROG && upload_ev;
	endsequence
	sequence s_left_prog;
		mode_r == OOVR_NORMAL ##1 !prog_led_out;
	endsequence
	sequence s_fail_end;
		mode_r == OOVR_FAIL && !bus_volt_low_in;
	endsequence

	AST_PROG_LED: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_PROG |=> prog_led_out) else $error("prog LED not lit"); // R1
	AST_UPLOAD_EXIT: assert property (@(posedge clock_in) disable iff (!nrst_in)
		s_upload_in_prog |=> s_left_prog) else $error("upload did not end prog mode"); // R2
	AST_NO_EARLY_TX: assert property (@(posedge clock_in) disable iff (!nrst_in)
		status_frame_out |-> $past(tx_enable_out)) else $error("frame before start-up delay"); // R3
	AST_FAIL_OFF: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_FAIL |=> out_switch_out == 8'h00) else $error("outputs on in bus failure"); // R4
	AST_RESUME: assert property (@(posedge clock_in) disable iff (!nrst_in)
		s_fail_end |=> mode_r == $past(saved_r) && out_state_r == $past(out_state_r))
		else $error("state not resumed"); // R5
	AST_ENTER_KEEP: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_NORMAL ##1 mode_r == OOVR_MANUAL |-> $stable(out_state_r))
		else $error("outputs changed on manual entry"); // R8
	AST_BUS_IGNORED: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_MANUAL && (bus_wr_ev || timed_wr_ev) && out_press == 8'h00 |=> $stable(out_state_r))
		else $error("bus changed output in manual"); // R9
	AST_MAN_NO_FRAME: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_MANUAL |=> !status_frame_out) else $error("frame from manual change"); // R10
	AST_MAN_LED: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_MANUAL && aux_ok_in == 2'b11 |=> led_out == $past(out_state_r))
		else $error("LEDs differ from outputs"); // R11
	AST_TOGGLE: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_MANUAL && out_press != 8'h00 |=> out_state_r == ($past(out_state_r) ^ $past(out_press)))
		else $error("key did not toggle output"); // R15
	AST_BLOCKED: assert property (@(posedge clock_in) disable iff (!nrst_in)
		mode_r == OOVR_NORMAL && blocked |=> mode_r != OOVR_MANUAL) else $error("blocked entry taken"); // R17
endmodule : oovr_top

// >>> verif/oovr_panel_model.sv
// Front panel keypad model with contact bounce on each press
`timescale 1ns/1ns
module oovr_panel_model #(
	parameter int MS_CYCLES = 4
) (
	input wire logic clock_in,
	input wire logic press_in,
	input wire logic [3:0] key_in,
	input wire logic [15:0] hold_ms_in,
	output logic prog_key_out,
	output logic manual_key_out,
	output logic [7:0] output_key_out,
	output logic busy_out
);
	int left_r;
	int age_r;
	logic [3:0] key_r;
	logic down;
	// Chatter first, so one press must still give one event
	assign down = busy_out && (age_r > 8 || age_r[1]);
	assign prog_key_out = down && key_r == 4'h9;
	assign manual_key_out = down && key_r == 4'h8;
	assign output_key_out = (down && key_r < 4'h8) ? 8'h01 << key_r[2:0] : 8'h00;
	initial begin
		busy_out = 1'b0;
		key_r = 4'h0;
		age_r = 0;
		left_r = 0;
	end
	always @(posedge clock_in) begin
		if (!busy_out && press_in) begin
			busy_out <= 1'b1;
			key_r <= key_in;
			age_r <= 0;
			left_r <= hold_ms_in * MS_CYCLES;
		end else if (busy_out) begin
			age_r <= age_r + 1;
			left_r <= left_r - 1;
			if (left_r == 0)
				busy_out <= 1'b0;
		end
	end
endmodule : oovr_panel_model

// >>> verif/oovr_top_tb_top.sv
// Self-checking bench for the output manual override block
`timescale 1ns/1ns
module oovr_top_tb_top import oovr_pkg::*;;
	localparam int MSC = 4;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic bus_low = 1'b0;
	logic [1:0] aux_ok = 2'h3;
	logic press = 1'b0;
	logic [3:0] key = 4'h0;
	logic [15:0] hold = 16'h0;
	logic hready, hresp, busy, pkey, mkey, pled, mled, tx, frame;
	logic [31:0] hrdata;
	logic [31:0] d;
	logic [7:0] okey, sw, led;
	logic [1:0] alarm;
	int failures = 0;
	int checks = 0;
	int frames = 0;
	int n;
	always #2 clk = ~clk;
	always @(posedge clk)
		if (frame === 1'b1)
			frames <= frames + 1;
	oovr_top #(.MS_CYCLES(MSC)) i_dut (.clock_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
		.hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .prog_key_in(pkey),
		.manual_key_in(mkey), .output_key_in(okey), .bus_volt_low_in(bus_low), .aux_ok_in(aux_ok),
		.out_switch_out(sw), .led_out(led), .prog_led_out(pled), .manual_led_out(mled),
		.tx_enable_out(tx), .status_frame_out(frame), .alarm_out(alarm));
	oovr_panel_model #(.MS_CYCLES(MSC)) i_panel (.clock_in(clk), .press_in(press), .key_in(key),
		.hold_ms_in(hold), .prog_key_out(pkey), .manual_key_out(mkey), .output_key_out(okey),
		.busy_out(busy));
	task close_out;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		d = hrdata;
		check("hresp", 0, hresp);
		// Let the write reach the output drivers
		repeat (3) @(posedge clk);
	endtask : xfer
	task push(input logic [3:0] k, input int ms);
		@(posedge clk);
		press <= 1'b1;
		key <= k;
		hold <= ms[15:0];
		@(posedge clk);
		press <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1) @(posedge clk);
		// Debounce needs two quiet samples after release
		repeat (30 * MSC) @(posedge clk);
	endtask : push
	task t_unconf;
		check("out_switch", 0, sw);
		check("prog_led", 0, pled);
		check("manual_led", 0, mled);
		xfer(1, ADDR_OUT_CMD, 32'hff);
		check("out_switch", 0, sw);
		push(8, 3050);
		check("manual_led", 1, mled);
		push(1, 50);
		check("out_switch", 8'h02, sw);
		push(8, 50);
		check("manual_led", 0, mled);
		check("tx_enable", 0, tx);
		check("frames", 0, frames);
	endtask : t_unconf
	task t_prog;
		push(9, 50);
		check("prog_led", 1, pled);
		repeat (100 * MSC) @(posedge clk);
		check("prog_led", 1, pled);
		xfer(0, ADDR_STATUS, 0);
		check("mode", 2'b10, d[1:0]);
		xfer(1, ADDR_EVENT, 32'h1);
		check("prog_led", 0, pled);
		xfer(0, ADDR_STATUS, 0);
		check("mode", 2'b00, d[1:0]);
	endtask : t_prog
	task t_bus;
		xfer(1, ADDR_TIMING, 32'h0001_0014);
		xfer(1, ADDR_CTRL, 32'h61);
		repeat (30 * MSC) @(posedge clk);
		check("tx_enable", 1, tx);
		xfer(1, ADDR_TIMED_CMD, 32'h5a);
		check("out_switch", 8'h5a, sw);
		n = frames;
		xfer(1, ADDR_OUT_CMD, 32'ha5);
		check("out_switch", 8'ha5, sw);
		check("frames", n + 1, frames);
	endtask : t_bus
	task t_manual;
		n = frames;
		push(8, 3050);
		check("manual_led", 1, mled);
		check("out_switch", 8'ha5, sw);
		xfer(1, ADDR_OUT_CMD, 32'h00);
		check("out_switch", 8'ha5, sw);
		xfer(1, ADDR_TIMED_CMD, 32'h00);
		check("out_switch", 8'ha5, sw);
		push(0, 50);
		check("out_switch", 8'ha4, sw);
		check("led", 8'ha4, led);
		push(0, 50);
		check("out_switch", 8'ha5, sw);
		push(7, 50);
		check("out_switch", 8'h25, sw);
		check("frames", n, frames);
		push(8, 50);
		check("manual_led", 0, mled);
		check("out_switch", 8'h25, sw);
		check("led", 8'h25, led);
		xfer(1, ADDR_OUT_CMD, 32'h3c);
		check("out_switch", 8'h3c, sw);
		xfer(0, ADDR_OUT_CMD, 0);
		check("out_state", 8'h3c, d[7:0]);
	endtask : t_manual
	task t_block;
		xfer(1, ADDR_CTRL, 32'h6d);
		push(8, 3050);
		check("manual_led", 0, mled);
		xfer(0, ADDR_STATUS, 0);
		check("mode", 2'b00, d[1:0]);
		xfer(1, ADDR_CTRL, 32'h63);
		xfer(0, ADDR_CTRL, 0);
		check("ctrl", 32'h63, d);
		push(8, 3050);
		check("manual_led", 0, mled);
	endtask : t_block
	task t_tmo;
		xfer(1, ADDR_CTRL, 32'h71);
		push(8, 3050);
		check("manual_led", 1, mled);
		repeat (1000 * MSC) @(posedge clk);
		check("manual_led", 0, mled);
		check("out_switch", 8'h3c, sw);
	endtask : t_tmo
	task t_aux;
		int on;
		int off;
		on = 0;
		off = 0;
		aux_ok <= 2'b10;
		repeat (24) begin
			repeat (50 * MSC) @(posedge clk);
			on += (led[3:0] === 4'hf);
			off += (led[3:0] === 4'h0);
		end
		check("blink", 1, on > 6 && off > 6);
		check("led_hi", 4'h3, led[7:4]);
		check("alarm", 2'b01, alarm);
		xfer(0, ADDR_STATUS, 0);
		check("aux_fault", 2'b01, d[4:3]);
		aux_ok <= 2'b11;
		repeat (50 * MSC) @(posedge clk);
		check("alarm", 2'b00, alarm);
	endtask : t_aux
	task t_fail;
		bus_low <= 1'b1;
		repeat (900 * MSC) @(posedge clk);
		check("out_switch", 8'h3c, sw);
		repeat (200 * MSC) @(posedge clk);
		check("out_switch", 0, sw);
		check("led", 0, led);
		xfer(0, ADDR_STATUS, 0);
		check("mode", 2'b11, d[1:0]);
		bus_low <= 1'b0;
		repeat (2 * MSC) @(posedge clk);
		check("out_switch", 8'h3c, sw);
		check("tx_enable", 0, tx);
		repeat (30 * MSC) @(posedge clk);
		check("tx_enable", 1, tx);
	endtask : t_fail
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_unconf();
		t_prog();
		t_bus();
		t_manual();
		t_block();
		t_tmo();
		t_aux();
		t_fail();
		close_out();
	end
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		close_out();
	end
endmodule : oovr_top_tb_top
